// File: design/mpg_cfg.svh
// Offsets, field positions, reset values and output function code of the pin value and role registers.
`ifndef MPG_CFG_SVH
`define MPG_CFG_SVH

// ****************************************************************
// Register offsets on page zero.
// ****************************************************************
`define MPG_ADDR_OUT_VALUES    8'h29
`define MPG_ADDR_BIDIR_MON     8'h2a
`define MPG_ADDR_ROLE_SEL_0    8'h2b
`define MPG_ADDR_ROLE_SEL_1    8'h2c

// ****************************************************************
// Field positions.
// ****************************************************************
`define MPG_BIT_BIDIR_LEVEL    7
`define MPG_BIT_OUT_TOP        6
`define MPG_BIT_OUT_LOW        3
`define MPG_BIT_MON_LEVEL      7
`define MPG_ROLE_HI_MSB        6
`define MPG_ROLE_HI_LSB        4
`define MPG_ROLE_LO_MSB        2
`define MPG_ROLE_LO_LSB        0

// ****************************************************************
// Reset values and function codes.
// ****************************************************************
`define MPG_RESET_BYTE         8'h00
`define MPG_OUT_FUNC_GPO       4'h1

`endif

// File: design/mpg_pkg.sv
// Types shared by the pin value and role logic.
package mpg_pkg;

  // Role encoding of an input-only pin.
  typedef enum logic [2:0] {
    MPG_ROLE_OFF   = 3'h0,
    MPG_ROLE_GPI   = 3'h1,
    MPG_ROLE_CLK   = 3'h2,
    MPG_ROLE_DAISY = 3'h3,
    MPG_ROLE_PDM12 = 3'h4,
    MPG_ROLE_PDM34 = 3'h5,
    MPG_ROLE_PDM56 = 3'h6,
    MPG_ROLE_PDM78 = 3'h7
  } mpg_role_t;

  // Decoded selections of one input-only pin.
  typedef struct packed {
    logic       general_input_role;
    logic       clk;
    logic       daisy;
    logic [3:0] pdm;
  } mpg_role_sel_t;

endpackage : mpg_pkg

// File: design/mpg_role_decode.sv
// Decoder from a three-bit role code to the selections of one input-only pin.
`timescale 1ns/10ps
`include "mpg_cfg.svh"

module mpg_role_decode (
  input  wire mpg_pkg::mpg_role_t     role,
  output mpg_pkg::mpg_role_sel_t      sel
);
  import mpg_pkg::*;

  // Every nonzero code selects exactly one function; code zero selects none.
  always_comb begin
    sel = '0;
    unique case (role)
      MPG_ROLE_OFF:   sel = '0;
      MPG_ROLE_GPI:   sel.general_input_role = 1'b1;
      MPG_ROLE_CLK:   sel.clk = 1'b1;
      MPG_ROLE_DAISY: sel.daisy = 1'b1;
      MPG_ROLE_PDM12: sel.pdm = 4'h1;
      MPG_ROLE_PDM34: sel.pdm = 4'h2;
      MPG_ROLE_PDM56: sel.pdm = 4'h4;
      MPG_ROLE_PDM78: sel.pdm = 4'h8;
    endcase
  end

endmodule : mpg_role_decode

// File: design/mpg_pins.sv
// Pin output values, bidirectional pin monitor and input pin role selection.
// Function
// RULE_01: Output value register resets zero, holds levels.
// RULE_02: Bit 7 drives bidirectional pin as output.
// RULE_03: Bits 6..3 drive output pins one..four.
// RULE_04: Monitor register bit 7 reads pin input.
// RULE_05: Monitor reads pin level; other bits zero.
// RULE_06: Role register 0 holds pins one, two.
// RULE_07: Codes 0..3 off, input, clock, daisy.
// RULE_08: Codes 4..7 select PDM data pairs.
// RULE_09: Pin two decodes the same codes.
// RULE_10: Role register 1 holds pins three, four.
// RULE_11: Pins three, four decode identically.
// RULE_12: Output pin follows value only in GENERAL_OUTPUT_ROLE.
// RULE_13: Reserved bits read zero; other roles ignore values.
`timescale 1ns/10ps
`include "mpg_cfg.svh"

module mpg_pins (
  input  wire logic                  mclk,
  input  wire logic                  srst,
  input  wire logic                  ctl_wr_en,
  input  wire logic                  ctl_rd_en,
  input  wire logic [7:0]            ctl_addr,
  input  wire logic [7:0]            ctl_wdata,
  output logic      [7:0]            ctl_rdata,
  input  wire logic                  bidir_pin_gpo_mode,
  input  wire logic                  bidir_pin_gpi_mode,
  input  wire logic                  bidir_pin_in,
  output logic                       bidir_pin_out,
  output logic                       bidir_pin_oe,
  input  wire logic [3:0]            out_pin_one_function,
  input  wire logic [3:0]            out_pin_two_function,
  input  wire logic [3:0]            out_pin_three_function,
  input  wire logic [3:0]            out_pin_four_function,
  output logic      [3:0]            out_pin_level,
  output logic      [3:0]            out_pin_gpo_active,
  input  wire logic [3:0]            in_pin,
  output logic      [3:0]            in_pin_gpi_level,
  output logic      [3:0]            controller_clock_sel,
  output logic                       daisy_chain_serial_in,
  output logic      [3:0]            pdm_data
);
  import mpg_pkg::*;

  // ****************************************************************
  // State.
  // ****************************************************************

  // All registers of the block in one record.
  typedef struct packed {
    logic [4:0]      out_values;     // Levels for bidir pin and output pins one..four.
    mpg_role_t [3:0] roles;          // Role codes of input pins one..four.
    logic            mon_level;      // Monitor bit of the bidirectional pin.
    logic [1:0]      bidir_sync;     // Two-stage synchroniser of the bidir pin.
    logic [3:0]      in_sync_a;      // First stage for input-only pins.
    logic [3:0]      in_sync_b;      // Second stage for input-only pins.
    logic [7:0]      rdata;          // Read data held for the control port.
    logic            bidir_out;      // Registered bidir pin level.
    logic            bidir_oe;       // Registered bidir pin enable.
    logic [3:0]      out_level;      // Registered output pin levels.
    logic [3:0]      out_active;     // Registered output pin GENERAL_OUTPUT_ROLE flags.
    logic [3:0]      gpi_level;      // Input pin levels seen as GENERAL_INPUT_ROLE.
    logic [3:0]      clk_sel;        // Pins chosen as controller clock.
    logic            daisy;          // Daisy-chain serial data.
    logic [3:0]      pdm;            // PDM data per channel pair.
  } mpg_state_t;

  mpg_state_t              st;        // Current state.
  mpg_state_t              next_st;   // Next state.
  mpg_role_sel_t [3:0]     role_sel;  // Decoded role of each input pin.
  logic [3:0][3:0]         out_func;  // Function codes of output pins one..four.

  assign out_func = {out_pin_four_function, out_pin_three_function,
                     out_pin_two_function, out_pin_one_function};

  // ****************************************************************
  // Role decoders, one per input pin.
  // ****************************************************************

  // Each input pin has its own decoder using the same encoding.
  for (genvar gi = 0; gi < 4; gi++) begin : g_dec
    mpg_role_decode mpg_role_decode_inst ( // RULE_09 RULE_11
      .role (st.roles[gi]),
      .sel  (role_sel[gi])
    );
  end

  // ****************************************************************
  // Next-state logic.
  // ****************************************************************

  // Computes register writes, read data, pin levels and routing.
  always_comb begin
    next_st = st;
    // The synchronisers shift the pin levels one stage along every cycle, so a level needs two cycles to cross both stages.
    next_st.bidir_sync = {st.bidir_sync[0], bidir_pin_in};
    next_st.in_sync_a  = in_pin;
    next_st.in_sync_b  = st.in_sync_a;
    // Register writes; reserved bits are dropped.
    if (ctl_wr_en) begin
      unique case (ctl_addr)
        `MPG_ADDR_OUT_VALUES: begin
          next_st.out_values = ctl_wdata[`MPG_BIT_BIDIR_LEVEL:`MPG_BIT_OUT_LOW]; // RULE_01 RULE_13
        end
        `MPG_ADDR_ROLE_SEL_0: begin
          next_st.roles[0] = mpg_role_t'(ctl_wdata[`MPG_ROLE_HI_MSB:`MPG_ROLE_HI_LSB]); // RULE_06
          next_st.roles[1] = mpg_role_t'(ctl_wdata[`MPG_ROLE_LO_MSB:`MPG_ROLE_LO_LSB]); // RULE_06
        end
        `MPG_ADDR_ROLE_SEL_1: begin
          next_st.roles[2] = mpg_role_t'(ctl_wdata[`MPG_ROLE_HI_MSB:`MPG_ROLE_HI_LSB]); // RULE_10
          next_st.roles[3] = mpg_role_t'(ctl_wdata[`MPG_ROLE_LO_MSB:`MPG_ROLE_LO_LSB]); // RULE_10
        end
        default: begin
          // Other addresses, the read-only monitor among them, take no write here.
        end
      endcase
    end
    // The monitor follows the pin only while it is a general input.
    if (bidir_pin_gpi_mode) begin
      next_st.mon_level = st.bidir_sync[1]; // RULE_04 RULE_05
    end
    // Read data is captured on the edge that takes the read strobe.
    if (ctl_rd_en) begin
      unique case (ctl_addr)
        `MPG_ADDR_OUT_VALUES: next_st.rdata = {st.out_values, 3'h0}; // RULE_13
        `MPG_ADDR_BIDIR_MON:  next_st.rdata = {st.mon_level, 7'h00}; // RULE_05
        `MPG_ADDR_ROLE_SEL_0: next_st.rdata = {1'b0, st.roles[0], 1'b0, st.roles[1]}; // RULE_13
        `MPG_ADDR_ROLE_SEL_1: next_st.rdata = {1'b0, st.roles[2], 1'b0, st.roles[3]}; // RULE_13
        default:              next_st.rdata = 8'h00;
      endcase
    end
    // Bidirectional pin drives its value bit only in output mode.
    next_st.bidir_oe  = bidir_pin_gpo_mode; // RULE_02
    next_st.bidir_out = bidir_pin_gpo_mode & st.out_values[4]; // RULE_02 RULE_13
    // Output-only pins follow their value bit only in the GENERAL_OUTPUT_ROLE function.
    for (int i = 0; i < 4; i++) begin
      next_st.out_active[i] = (out_func[i] == `MPG_OUT_FUNC_GPO); // RULE_12
      next_st.out_level[i]  = next_st.out_active[i] & st.out_values[3 - i]; // RULE_03 RULE_12
    end
    // Input routing; the lowest-numbered pin wins a shared function.
    next_st.daisy = 1'b0;
    next_st.pdm   = 4'h0;
    for (int i = 3; i >= 0; i--) begin
      next_st.gpi_level[i] = role_sel[i].general_input_role & st.in_sync_b[i]; // RULE_07
      next_st.clk_sel[i]   = role_sel[i].clk; // RULE_07
      if (role_sel[i].daisy) begin
        next_st.daisy = st.in_sync_b[i]; // RULE_07
      end
      for (int k = 0; k < 4; k++) begin
        if (role_sel[i].pdm[k]) begin
          next_st.pdm[k] = st.in_sync_b[i]; // RULE_08
        end
      end
    end
  end

  // ****************************************************************
  // State register.
  // ****************************************************************

  // Synchronous reset clears every register to zero.
  always_ff @(posedge mclk) begin
    if (srst) begin
      st <= '0; // RULE_01 RULE_04 RULE_06 RULE_10
    end else begin
      st <= next_st;
    end
  end

  assign ctl_rdata             = st.rdata;
  assign bidir_pin_out         = st.bidir_out;
  assign bidir_pin_oe          = st.bidir_oe;
  assign out_pin_level         = st.out_level;
  assign out_pin_gpo_active    = st.out_active;
  assign in_pin_gpi_level      = st.gpi_level;
  assign controller_clock_sel  = st.clk_sel;
  assign daisy_chain_serial_in = st.daisy;
  assign pdm_data              = st.pdm;

  // ****************************************************************
  // Checks.
  // ****************************************************************

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  // A write to the value register, an idle cycle and a read give it back, reserved bits zero.
  chk_value_readback: assert property ( // RULE_01
    ctl_wr_en && ctl_addr == `MPG_ADDR_OUT_VALUES ##1 !ctl_wr_en
    ##1 ctl_rd_en && ctl_addr == `MPG_ADDR_OUT_VALUES && !ctl_wr_en
    |=> ctl_rdata == {$past(ctl_wdata, 3) & 8'hf8})
    else $error("value register readback wrong");

  // Bidir pin level follows bit 7 in output mode.
  chk_bidir_drive: assert property ( // RULE_02
    bidir_pin_gpo_mode |=> bidir_pin_oe && bidir_pin_out == $past(st.out_values[4]))
    else $error("bidir pin drive wrong");

  // Output pin one follows bit 6 only in GENERAL_OUTPUT_ROLE function.
  chk_out_pin_one: assert property ( // RULE_03
    1'b1 |=> out_pin_level[0] ==
    ($past(out_pin_one_function) == `MPG_OUT_FUNC_GPO && $past(st.out_values[3])))
    else $error("output pin one level wrong");

  // Output pin four outside the GENERAL_OUTPUT_ROLE function stays low and inactive.
  chk_out_other_role: assert property ( // RULE_12
    out_pin_four_function != `MPG_OUT_FUNC_GPO |=> !out_pin_level[3] && !out_pin_gpo_active[3])
    else $error("output pin four driven outside GENERAL_OUTPUT_ROLE");

  // The monitor shows a held pin level after two sync stages and its own stage.
  chk_monitor_level: assert property ( // RULE_04
    bidir_pin_gpi_mode && bidir_pin_in ##1 bidir_pin_gpi_mode && bidir_pin_in
    ##1 bidir_pin_gpi_mode |=> st.mon_level)
    else $error("monitor level not captured");

  // Monitor reads keep the seven low bits at zero.
  chk_monitor_zero: assert property ( // RULE_05
    ctl_rd_en && ctl_addr == `MPG_ADDR_BIDIR_MON |=> ctl_rdata[6:0] == 7'h00)
    else $error("monitor reserved bits nonzero");

  // Role register 0 read back places both fields.
  chk_role_fields: assert property ( // RULE_06
    ctl_rd_en && ctl_addr == `MPG_ADDR_ROLE_SEL_0 && !ctl_wr_en
    |=> ctl_rdata == {1'b0, $past(st.roles[0]), 1'b0, $past(st.roles[1])})
    else $error("role register 0 readback wrong");

  // Pin one coded for PDM channels 5-6 always wins and passes its level through.
  chk_pdm_route: assert property ( // RULE_08
    st.roles[0] == MPG_ROLE_PDM56 |=> pdm_data[2] == $past(st.in_sync_b[0]))
    else $error("PDM route wrong");

  // Pin four coded as controller clock is selected.
  chk_clock_select: assert property ( // RULE_11
    st.roles[3] == MPG_ROLE_CLK |=> controller_clock_sel[3])
    else $error("clock select missing");

endmodule : mpg_pins

// File: test/tb_multipurpose_pin_value_and_input_select.sv
// Self-checking bench for the pin value, monitor and input role registers.
`timescale 1ns/10ps
`include "mpg_cfg.svh"

module tb_multipurpose_pin_value_and_input_select;
  import mpg_pkg::*;
  // ****************************************************************
  // Stimulus and observation signals.
  // ****************************************************************
  logic       mclk, srst, ctl_wr_en, ctl_rd_en, bidir_pin_gpo_mode, bidir_pin_gpi_mode;
  logic       bidir_pin_in, bidir_pin_out, bidir_pin_oe, daisy_chain_serial_in, rd_pend;
  logic [7:0] ctl_addr, ctl_wdata, ctl_rdata, v;
  logic [3:0] out_pin_one_function, out_pin_two_function, out_pin_three_function;
  logic [3:0] out_pin_four_function, out_pin_level, out_pin_gpo_active, in_pin;
  logic [3:0] in_pin_gpi_level, controller_clock_sel, pdm_data, f, p;
  logic [2:0] r;
  logic [7:0] exp_q[$];       // Read results noted by the driver, oldest first.
  int         fail_count, samples_checked, i;
  int         seed = 32'h8afbdf8a;

  mpg_pins mpg_pins_inst (.mclk(mclk), .srst(srst), .ctl_wr_en(ctl_wr_en),
    .ctl_rd_en(ctl_rd_en), .ctl_addr(ctl_addr), .ctl_wdata(ctl_wdata), .ctl_rdata(ctl_rdata),
    .bidir_pin_gpo_mode(bidir_pin_gpo_mode), .bidir_pin_gpi_mode(bidir_pin_gpi_mode),
    .bidir_pin_in(bidir_pin_in), .bidir_pin_out(bidir_pin_out), .bidir_pin_oe(bidir_pin_oe),
    .out_pin_one_function(out_pin_one_function), .out_pin_two_function(out_pin_two_function),
    .out_pin_three_function(out_pin_three_function),
    .out_pin_four_function(out_pin_four_function), .out_pin_level(out_pin_level),
    .out_pin_gpo_active(out_pin_gpo_active), .in_pin(in_pin),
    .in_pin_gpi_level(in_pin_gpi_level), .controller_clock_sel(controller_clock_sel),
    .daisy_chain_serial_in(daisy_chain_serial_in), .pdm_data(pdm_data));

  // The 125 MHz clock toggles every 4 ns.
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // ****************************************************************
  // Shared tasks.
  // ****************************************************************
  // Compares a seen value with its expectation and counts the outcome.
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One write strobe, then an idle cycle so strobes never merge.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    ctl_wr_en = 1'b1;
    ctl_addr = a;
    ctl_wdata = d;
    @(negedge mclk);
    ctl_wr_en = 1'b0;
    @(negedge mclk);
  endtask : wr

  // One read strobe; the expected byte is noted for the watcher.
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    ctl_rd_en = 1'b1;
    ctl_addr = a;
    exp_q.push_back(e);
    @(negedge mclk);
    ctl_rd_en = 1'b0;
    @(negedge mclk);
  endtask : rd

  // Checks all routed input pin outputs at once.
  task automatic chk_roles(input logic [3:0] g, c, input logic d, input logic [3:0] m);
    chk({4'h0, in_pin_gpi_level}, {4'h0, g});
    chk({4'h0, controller_clock_sel}, {4'h0, c});
    chk({7'h0, daisy_chain_serial_in}, {7'h0, d});
    chk({4'h0, pdm_data}, {4'h0, m});
  endtask : chk_roles

  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up

  // ****************************************************************
  // Watcher: read data stands the cycle after the strobe is taken.
  // ****************************************************************
  always @(posedge mclk) rd_pend <= ctl_rd_en && !srst;
  always @(negedge mclk) begin
    if (rd_pend) begin
      if (exp_q.size() == 0) chk(ctl_rdata, 8'hxx);
      else chk(ctl_rdata, exp_q.pop_front());
    end
  end

  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial begin
    {srst, ctl_wr_en, ctl_rd_en, ctl_addr, ctl_wdata} = {1'b1, 18'h0};
    {bidir_pin_gpo_mode, bidir_pin_gpi_mode, bidir_pin_in, in_pin} = 7'h0;
    {out_pin_one_function, out_pin_two_function} = 8'h0;
    {out_pin_three_function, out_pin_four_function} = 8'h0;
    repeat (8) @(negedge mclk);
    srst = 1'b0;
    // Reset values, then reserved bits and an unmapped place.
    for (i = 8'h29; i <= 8'h2d; i++) rd(8'(i), 8'h00);
    wr(`MPG_ADDR_OUT_VALUES, 8'hff);
    rd(`MPG_ADDR_OUT_VALUES, 8'hf8);
    wr(`MPG_ADDR_ROLE_SEL_0, 8'hff);
    rd(`MPG_ADDR_ROLE_SEL_0, 8'h77);
    wr(`MPG_ADDR_ROLE_SEL_1, 8'hff);
    rd(`MPG_ADDR_ROLE_SEL_1, 8'h77);
    $display("test registers done");
    // Output values against random functions and bidirectional mode.
    for (i = 0; i < 8; i++) begin
      v = 8'($random(seed));
      f = 4'($random(seed));
      bidir_pin_gpo_mode = v[0];
      out_pin_one_function = f[0] ? `MPG_OUT_FUNC_GPO : 4'h2;
      out_pin_two_function = f[1] ? `MPG_OUT_FUNC_GPO : 4'h3;
      out_pin_three_function = f[2] ? `MPG_OUT_FUNC_GPO : 4'h0;
      out_pin_four_function = f[3] ? `MPG_OUT_FUNC_GPO : 4'h4;
      wr(`MPG_ADDR_OUT_VALUES, v);
      chk({4'h0, out_pin_level}, {4'h0, f & {v[3], v[4], v[5], v[6]}});
      chk({4'h0, out_pin_gpo_active}, {4'h0, f});
      chk({6'h0, bidir_pin_out, bidir_pin_oe}, {6'h0, v[0] & v[7], v[0]});
    end
    bidir_pin_gpo_mode = 1'b0;
    $display("test outputs done");
    // Every role code on all four pins; the lowest pin wins shared roles.
    for (i = 0; i < 8; i++) begin
      r = 3'(i);
      p = 4'($random(seed));
      in_pin = p;
      wr(`MPG_ADDR_ROLE_SEL_0, {1'b0, r, 1'b0, r});
      wr(`MPG_ADDR_ROLE_SEL_1, {1'b0, r, 1'b0, r});
      chk_roles(r == 1 ? p : 4'h0, r == 2 ? 4'hf : 4'h0, r == 3 && p[0],
                r >= 4 ? 4'(p[0]) << (r - 3'h4) : 4'h0);
    end
    // Distinct roles expose each pin's own field.
    p = 4'($random(seed));
    in_pin = p;
    wr(`MPG_ADDR_ROLE_SEL_0, 8'h14);
    wr(`MPG_ADDR_ROLE_SEL_1, 8'h23);
    rd(`MPG_ADDR_ROLE_SEL_0, 8'h14);
    rd(`MPG_ADDR_ROLE_SEL_1, 8'h23);
    chk_roles({3'h0, p[0]}, 4'h4, p[3], {3'h0, p[1]});
    $display("test roles done");
    // Monitor follows the pin in input mode and holds outside it.
    bidir_pin_gpi_mode = 1'b1;
    bidir_pin_in = 1'b1;
    wr(`MPG_ADDR_BIDIR_MON, 8'h7f);
    // Two sync stages and the monitor stage must pass before the read edge.
    @(negedge mclk);
    rd(`MPG_ADDR_BIDIR_MON, 8'h80);
    bidir_pin_in = 1'b0;
    repeat (4) @(negedge mclk);
    rd(`MPG_ADDR_BIDIR_MON, 8'h00);
    bidir_pin_gpi_mode = 1'b0;
    bidir_pin_in = 1'b1;
    repeat (4) @(negedge mclk);
    rd(`MPG_ADDR_BIDIR_MON, 8'h00);
    $display("test monitor done");
    // Bounded wait for the watcher to take every noted read.
    for (i = 0; i < 10 && exp_q.size() != 0; i++) @(negedge mclk);
    if (exp_q.size() != 0) chk(8'h00, 8'h01);
    wrap_up();
  end
endmodule : tb_multipurpose_pin_value_and_input_select
